// ---- verilog/csf_pkg.sv ----
// Behaviour
// RULE1: eight-bit status holding seven flags
// RULE2: carry follows carry out of bit seven
// RULE3: set-carry forces one, clear-carry forces zero
// RULE4: carry also from add, shift, compare, pull
// RULE5: zero set when all result bits zero
// RULE6: zero changes only through result operations
// RULE7: mask clear services requests, set ignores
// RULE8: reset and interrupt entries set mask
// RULE9: mask ops, break set; pull reloads mask
// RULE10: decimal flag selects bcd adder mode
// RULE11: decimal changes only by ops and pulls
// RULE12: decimal power-up value undefined; software initialises
// RULE13: break flag tells software from hardware entry
// RULE14: no operation writes break flag directly
// RULE15: overflow on signed range escape in add/sub
// RULE16: clear-overflow forces zero; few others change it
// RULE17: bit-test loads overflow from operand bit six
// RULE18: negative loads result bit seven
// RULE19: negative changes only with zero's ops, bit-test
// RULE20: flags at customary bit positions
`default_nettype none
package csf_pkg;
  localparam int POS_CARRY = 0;
  localparam int POS_ZERO = 1;
  localparam int POS_IRQ_MASK = 2;
  localparam int POS_DECIMAL = 3;
  localparam int POS_BREAK = 4;
  localparam int POS_UNUSED = 5;
  localparam int POS_OVERFLOW = 6;
  localparam int POS_NEGATIVE = 7;
  localparam int POS_SIGN = 7;
  localparam int POS_BIT_TEST_V = 6;
  localparam logic RST_CARRY = 1'h0;
  localparam logic RST_ZERO = 1'h0;
  localparam logic RST_IRQ_MASK = 1'h1;
  localparam logic RST_BREAK = 1'h0;
  localparam logic RST_OVERFLOW = 1'h0;
  localparam logic RST_NEGATIVE = 1'h0;
  localparam logic UNUSED_VAL = 1'h0;
  localparam logic DEC_POWERUP_VAL = 1'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_ADJ = 4'h6;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_ADD = 5'h01,
    OP_SUB = 5'h02,
    OP_CMP = 5'h03,
    OP_RESULT = 5'h04,
    OP_SHL = 5'h05,
    OP_SHR = 5'h06,
    OP_ROL = 5'h07,
    OP_ROR = 5'h08,
    OP_BIT = 5'h09,
    OP_PULL = 5'h0A,
    OP_RETURN_INT = 5'h0B,
    OP_SEC = 5'h0C,
    OP_CLEAR_CARRY = 5'h0D,
    OP_SET_MASK = 5'h0E,
    OP_CLEAR_MASK = 5'h0F,
    OP_SET_DEC = 5'h10,
    OP_CLEAR_DEC = 5'h11,
    OP_CLEAR_OVF = 5'h12,
    OP_SW_BREAK = 5'h13
  } csf_opkind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_PUSH = 3'h2,
    ST_MASK = 3'h4
  } csf_state_t;

  typedef struct packed {
    logic opValid;
    csf_opkind_t kind;
    logic [7:0] operandA;
    logic [7:0] operandB;
    logic [7:0] result;
    logic [7:0] pulled;
  } csf_op_t;

  typedef struct packed {
    logic irqReq;
    logic nmiReq;
  } csf_intr_t;

  typedef struct packed {
    logic pushValid;
    logic breakCause;
    logic [7:0] pushedStatus;
  } csf_entry_t;
endpackage
`default_nettype wire

// ---- verilog/csf_adder.sv ----
`default_nettype none
module csf_adder
  import csf_pkg::*;
(
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carryIn,
  input wire logic subtract,
  input wire logic decimal,
  output logic [7:0] sum,
  output logic carryOut,
  output logic overflow
);
  logic [7:0] bEff;
  logic [8:0] binSum;
  logic [4:0] lo;
  logic [4:0] hi;
  logic loCarry;
  logic [7:0] decHalf;

  assign bEff = subtract ? ~b : b;
  assign binSum = {1'b0, a} + {1'b0, bEff} + {8'h00, carryIn};

  always_comb begin
    lo = {1'b0, a[3:0]} + {1'b0, bEff[3:0]} + {4'h0, carryIn};
    loCarry = lo[4];
    hi = 5'h00;
    sum = binSum[7:0];
    carryOut = binSum[8];
    decHalf = binSum[7:0];
    if (decimal && !subtract) begin
      if (lo > {1'b0, BCD_LIMIT}) begin
        lo = lo + {1'b0, BCD_ADJ};
        loCarry = 1'b1;
      end
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, loCarry};
      // overflow is taken before the upper nibble is corrected
      decHalf = {hi[3:0], lo[3:0]};
      if (hi > {1'b0, BCD_LIMIT}) begin
        hi = hi + {1'b0, BCD_ADJ};
      end
      sum = {hi[3:0], lo[3:0]};
      carryOut = hi[4] || (hi[3:0] < BCD_ADJ && loCarry && a[7] && b[7]);
      carryOut = carryOut || (hi > 5'h0F);
    end else if (decimal && subtract) begin
      // borrow from each nibble takes six off that nibble
      sum[3:0] = loCarry ? binSum[3:0] : binSum[3:0] - BCD_ADJ;
      sum[7:4] = binSum[8] ? binSum[7:4] : binSum[7:4] - BCD_ADJ;
    end
  end

  // signed overflow when both inputs share a sign the result lacks
  assign overflow = (a[7] == bEff[7]) && (decHalf[7] != a[7]); // RULE15
endmodule
`default_nettype wire

// ---- verilog/csf_status_flags.sv ----
`default_nettype none
module csf_status_flags
  import csf_pkg::*;
#(
  parameter logic DEC_POWERUP = DEC_POWERUP_VAL
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire csf_op_t opIn,
  input wire csf_intr_t intrIn,
  output logic [7:0] statusOut,
  output logic [7:0] aluOut,
  output logic aluValid,
  output csf_entry_t entryOut,
  output logic entryBusy,
  output logic decimalMode,
  output logic irqServiced
);
  logic carry_ff;
  logic zero_ff;
  logic irqMask_ff;
  logic breakFlag_ff;
  logic overflow_ff;
  logic negative_ff;
  // no reset on purpose: power-up value is unpredictable to software
  logic decimal_ff = DEC_POWERUP;
  logic causeSwBreak_ff;
  csf_state_t state_ff;
  logic entryBusy_ff;
  csf_state_t nxt_state;
  logic [7:0] status_ff;
  logic [7:0] aluOut_ff;
  logic aluValid_ff;
  csf_entry_t entry_ff;
  logic irqServiced_ff;

  logic nxt_carry;
  logic nxt_zero;
  logic nxt_irqMask;
  logic nxt_decimal;
  logic nxt_overflow;
  logic nxt_negative;
  logic [7:0] nxt_status;

  logic opAct;
  logic isAdd;
  logic isSub;
  logic isCmp;
  logic isShift;
  logic isPull;
  logic isBit;
  logic nzUpdate;
  logic [7:0] opResult;
  logic [7:0] addSum;
  logic addCarry;
  logic addOverflow;
  logic adderSub;
  logic adderCarryIn;
  logic adderDecimal;
  logic irqAccept;
  logic swBreakAccept;
  logic nmiAccept;
  logic entryStart;
  logic [7:0] curStatus;

  // ops are refused while an interrupt entry is in progress
  assign opAct = opIn.opValid && (state_ff == ST_IDLE);
  assign isAdd = opAct && (opIn.kind == OP_ADD);
  assign isSub = opAct && (opIn.kind == OP_SUB);
  assign isCmp = opAct && (opIn.kind == OP_CMP);
  assign isBit = opAct && (opIn.kind == OP_BIT);
  assign isPull = opAct && (opIn.kind == OP_PULL ||
                            opIn.kind == OP_RETURN_INT);
  assign isShift = opAct && (opIn.kind == OP_SHL || opIn.kind == OP_SHR ||
                             opIn.kind == OP_ROL || opIn.kind == OP_ROR);

  // compare is always binary and never borrows in
  assign adderSub = isSub || isCmp;
  assign adderCarryIn = isCmp ? 1'b1 : carry_ff;
  assign adderDecimal = decimal_ff && !isCmp; // RULE10

  csf_adder u_adder (
    .a(opIn.operandA),
    .b(opIn.operandB),
    .carryIn(adderCarryIn),
    .subtract(adderSub),
    .decimal(adderDecimal),
    .sum(addSum),
    .carryOut(addCarry),
    .overflow(addOverflow)
  );

  always_comb begin
    opResult = opIn.result;
    nzUpdate = 1'b0;
    if (opAct) begin
      case (opIn.kind)
        OP_ADD, OP_SUB, OP_CMP: begin
          opResult = addSum;
          nzUpdate = 1'b1;
        end
        OP_SHL: begin
          opResult = {opIn.operandA[6:0], 1'b0};
          nzUpdate = 1'b1;
        end
        OP_SHR: begin
          opResult = {1'b0, opIn.operandA[7:1]};
          nzUpdate = 1'b1;
        end
        OP_ROL: begin
          opResult = {opIn.operandA[6:0], carry_ff};
          nzUpdate = 1'b1;
        end
        OP_ROR: begin
          opResult = {carry_ff, opIn.operandA[7:1]};
          nzUpdate = 1'b1;
        end
        OP_RESULT: begin
          opResult = opIn.result;
          nzUpdate = 1'b1;
        end
        default: begin
          opResult = opIn.result;
          nzUpdate = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    nxt_carry = carry_ff;
    if (opAct) begin
      case (opIn.kind)
        OP_ADD, OP_SUB, OP_CMP: nxt_carry = addCarry; // RULE2 RULE4
        OP_SHL, OP_ROL: nxt_carry = opIn.operandA[7]; // RULE4
        OP_SHR, OP_ROR: nxt_carry = opIn.operandA[0]; // RULE4
        OP_PULL, OP_RETURN_INT: nxt_carry = opIn.pulled[POS_CARRY]; // RULE4
        OP_SEC: nxt_carry = 1'b1; // RULE3
        OP_CLEAR_CARRY: nxt_carry = 1'b0; // RULE3
        default: nxt_carry = carry_ff;
      endcase
    end
  end

  // zero and negative have no direct set or clear op
  always_comb begin
    nxt_zero = zero_ff;
    nxt_negative = negative_ff;
    if (nzUpdate) begin
      nxt_zero = (opResult == BYTE_ZERO); // RULE5 RULE6
      nxt_negative = opResult[POS_SIGN]; // RULE18 RULE19
    end else if (isBit) begin
      nxt_zero = ((opIn.operandA & opIn.operandB) == BYTE_ZERO); // RULE5
      nxt_negative = opIn.operandB[POS_SIGN]; // RULE19
    end else if (isPull) begin
      nxt_zero = opIn.pulled[POS_ZERO]; // RULE6
      nxt_negative = opIn.pulled[POS_NEGATIVE]; // RULE19
    end
  end

  always_comb begin
    nxt_overflow = overflow_ff;
    if (isAdd || isSub) begin
      nxt_overflow = addOverflow; // RULE15
    end else if (isBit) begin
      nxt_overflow = opIn.operandB[POS_BIT_TEST_V]; // RULE17
    end else if (isPull) begin
      nxt_overflow = opIn.pulled[POS_OVERFLOW]; // RULE16
    end else if (opAct && opIn.kind == OP_CLEAR_OVF) begin
      nxt_overflow = 1'b0; // RULE16
    end
  end

  always_comb begin
    nxt_decimal = decimal_ff;
    if (opAct && opIn.kind == OP_SET_DEC) begin
      nxt_decimal = 1'b1; // RULE11
    end else if (opAct && opIn.kind == OP_CLEAR_DEC) begin
      nxt_decimal = 1'b0; // RULE11
    end else if (isPull) begin
      nxt_decimal = opIn.pulled[POS_DECIMAL]; // RULE11
    end
  end

  // entry priority: non-maskable, then break, then masked request
  assign nmiAccept = (state_ff == ST_IDLE) && intrIn.nmiReq; // RULE8
  assign swBreakAccept = opAct && (opIn.kind == OP_SW_BREAK) && !nmiAccept;
  assign irqAccept = (state_ff == ST_IDLE) && intrIn.irqReq && !irqMask_ff &&
                     !nmiAccept && !swBreakAccept; // RULE7
  assign entryStart = nmiAccept || swBreakAccept || irqAccept;

  always_comb begin
    nxt_irqMask = irqMask_ff;
    if (state_ff == ST_MASK) begin
      nxt_irqMask = 1'b1; // RULE8 RULE9
    end else if (opAct && opIn.kind == OP_SET_MASK) begin
      nxt_irqMask = 1'b1; // RULE9
    end else if (opAct && opIn.kind == OP_CLEAR_MASK) begin
      nxt_irqMask = 1'b0; // RULE9
    end else if (isPull) begin
      nxt_irqMask = opIn.pulled[POS_IRQ_MASK]; // RULE9
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (entryStart) begin
          nxt_state = ST_PUSH;
        end
      end
      ST_PUSH: begin
        nxt_state = ST_MASK;
      end
      ST_MASK: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    curStatus = BYTE_ZERO;
    curStatus[POS_CARRY] = carry_ff;
    curStatus[POS_ZERO] = zero_ff;
    curStatus[POS_IRQ_MASK] = irqMask_ff;
    curStatus[POS_DECIMAL] = decimal_ff;
    curStatus[POS_BREAK] = breakFlag_ff;
    curStatus[POS_UNUSED] = UNUSED_VAL;
    curStatus[POS_OVERFLOW] = overflow_ff;
    curStatus[POS_NEGATIVE] = negative_ff;
  end

  always_comb begin
    nxt_status = BYTE_ZERO; // RULE1 RULE20
    nxt_status[POS_CARRY] = nxt_carry;
    nxt_status[POS_ZERO] = nxt_zero;
    nxt_status[POS_IRQ_MASK] = nxt_irqMask;
    nxt_status[POS_DECIMAL] = nxt_decimal;
    nxt_status[POS_BREAK] = (state_ff == ST_MASK) ? causeSwBreak_ff :
                            breakFlag_ff;
    nxt_status[POS_UNUSED] = UNUSED_VAL;
    nxt_status[POS_OVERFLOW] = nxt_overflow;
    nxt_status[POS_NEGATIVE] = nxt_negative;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      carry_ff <= RST_CARRY;
      zero_ff <= RST_ZERO;
      overflow_ff <= RST_OVERFLOW;
      negative_ff <= RST_NEGATIVE;
    end else begin
      carry_ff <= nxt_carry;
      zero_ff <= nxt_zero;
      overflow_ff <= nxt_overflow;
      negative_ff <= nxt_negative;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqMask_ff <= RST_IRQ_MASK; // RULE8
    end else begin
      irqMask_ff <= nxt_irqMask;
    end
  end

  // reset leaves decimal alone; software must set it before arithmetic
  always_ff @(posedge clk_sys) begin
    if (!rst) begin
      decimal_ff <= nxt_decimal; // RULE11 RULE12
    end
  end

  // only interrupt entry writes the break flag, pulls keep it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      breakFlag_ff <= RST_BREAK;
      causeSwBreak_ff <= 1'b0;
    end else begin
      if (state_ff == ST_IDLE && entryStart) begin
        causeSwBreak_ff <= swBreakAccept;
      end
      if (state_ff == ST_MASK) begin
        breakFlag_ff <= causeSwBreak_ff; // RULE13 RULE14
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      entryBusy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // registered busy so the output comes straight from a flop
      entryBusy_ff <= (nxt_state != ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_ff <= {RST_NEGATIVE, RST_OVERFLOW, UNUSED_VAL, RST_BREAK,
                    decimal_ff, RST_IRQ_MASK, RST_ZERO, RST_CARRY};
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aluOut_ff <= BYTE_ZERO;
      aluValid_ff <= 1'b0;
    end else begin
      aluValid_ff <= nzUpdate;
      if (nzUpdate) begin
        aluOut_ff <= opResult;
      end
    end
  end

  // pushed byte carries the cause so the handler can tell them apart
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      entry_ff <= '0;
      irqServiced_ff <= 1'b0;
    end else begin
      irqServiced_ff <= irqAccept; // RULE7
      entry_ff.pushValid <= (state_ff == ST_PUSH);
      entry_ff.breakCause <= (state_ff == ST_PUSH) ? causeSwBreak_ff : 1'b0;
      if (state_ff == ST_PUSH) begin
        entry_ff.pushedStatus <= curStatus;
        entry_ff.pushedStatus[POS_BREAK] <= causeSwBreak_ff; // RULE13
      end
    end
  end

  assign statusOut = status_ff;
  assign aluOut = aluOut_ff;
  assign aluValid = aluValid_ff;
  assign entryOut = entry_ff;
  assign entryBusy = entryBusy_ff;
  assign decimalMode = decimal_ff;
  assign irqServiced = irqServiced_ff;
endmodule
`default_nettype wire

// ---- sim/csf_status_flags_properties.sv ----
`default_nettype none
module csf_status_flags_properties
  import csf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire csf_op_t opIn,
  input wire csf_intr_t intrIn,
  input wire logic [7:0] statusOut,
  input wire logic [7:0] aluOut,
  input wire logic aluValid,
  input wire csf_entry_t entryOut,
  input wire logic entryBusy,
  input wire logic decimalMode,
  input wire logic irqServiced
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic take;
  logic addOvf;
  logic resZero;
  logic dOp;
  logic [8:0] binSum;
  // ops during an entry are dropped, so only count accepted ones
  assign take = opIn.opValid && !entryBusy;
  assign binSum = {1'b0, opIn.operandA} + {1'b0, opIn.operandB}
    + {8'h00, statusOut[POS_CARRY]};
  assign addOvf = (opIn.operandA[7] == opIn.operandB[7])
    && (binSum[7] != opIn.operandA[7]);
  assign resZero = opIn.result == BYTE_ZERO;
  assign dOp = opIn.kind inside {OP_SET_DEC, OP_CLEAR_DEC, OP_PULL,
    OP_RETURN_INT};

  a_carry_force: assert property (
    take && (opIn.kind == OP_SEC || opIn.kind == OP_CLEAR_CARRY) |=>
    statusOut[POS_CARRY] == $past(opIn.kind == OP_SEC))
    else $error("carry not forced by set or clear");
  // binary mode only: decimal carry follows the corrected sum
  a_add_carry: assert property (
    take && opIn.kind == OP_ADD && !decimalMode |=>
    statusOut[POS_CARRY] == $past(binSum[8]))
    else $error("add carry wrong");
  a_add_overflow: assert property (
    take && opIn.kind == OP_ADD && !decimalMode |=>
    statusOut[POS_OVERFLOW] == $past(addOvf))
    else $error("add overflow wrong");
  a_result_nz: assert property (
    take && opIn.kind == OP_RESULT |=> statusOut[POS_ZERO] == $past(resZero)
    && statusOut[POS_NEGATIVE] == $past(opIn.result[7]))
    else $error("zero or negative wrong after result");
  a_bit_test: assert property (
    take && opIn.kind == OP_BIT |=>
    statusOut[POS_OVERFLOW] == $past(opIn.operandB[6])
    && statusOut[POS_NEGATIVE] == $past(opIn.operandB[7]))
    else $error("bit test flags wrong");
  a_clear_ovf: assert property (
    take && opIn.kind == OP_CLEAR_OVF |=> !statusOut[POS_OVERFLOW])
    else $error("overflow not cleared");
  a_decimal_hold: assert property (
    !(take && dOp) |=> $stable(decimalMode)
    && decimalMode == statusOut[POS_DECIMAL])
    else $error("decimal flag changed without cause");
  a_irq_masked: assert property (
    intrIn.irqReq && statusOut[POS_IRQ_MASK] |=> !irqServiced)
    else $error("masked request serviced");
  a_irq_entry: assert property (
    intrIn.irqReq && !statusOut[POS_IRQ_MASK] && !entryBusy
    && !intrIn.nmiReq && !(opIn.opValid && opIn.kind == OP_SW_BREAK)
    |=> irqServiced && entryBusy
    ##1 entryOut.pushValid && !entryOut.pushedStatus[POS_BREAK]
    ##1 statusOut[POS_IRQ_MASK] && !statusOut[POS_BREAK] && !entryBusy)
    else $error("request entry sequence wrong");
  a_brk_entry: assert property (
    take && opIn.kind == OP_SW_BREAK && !intrIn.nmiReq |=>
    entryBusy && !irqServiced
    ##1 entryOut.breakCause && entryOut.pushedStatus[POS_BREAK]
    ##1 statusOut[POS_IRQ_MASK] && statusOut[POS_BREAK])
    else $error("break entry sequence wrong");
  a_spare_bit: assert property (
    statusOut[POS_UNUSED] == UNUSED_VAL)
    else $error("spare status bit not zero");
endmodule

bind csf_status_flags csf_status_flags_properties u_props (
  .clk_sys(clk_sys), .rst(rst), .opIn(opIn), .intrIn(intrIn),
  .statusOut(statusOut), .aluOut(aluOut), .aluValid(aluValid),
  .entryOut(entryOut), .entryBusy(entryBusy),
  .decimalMode(decimalMode), .irqServiced(irqServiced)
);
`default_nettype wire

// ---- sim/csf_status_flags_tb.sv ----
`default_nettype none
module csf_status_flags_tb
  import csf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // al: 0 no result, 1 result checked, 2 result not checked
  typedef struct {
    csf_opkind_t k;
    logic [7:0] a, b, st, alu;
    logic [1:0] al;
  } csf_row_t;
  logic clk_sys;
  logic rst;
  csf_op_t opIn;
  csf_intr_t intrIn;
  logic [7:0] statusOut, aluOut;
  logic aluValid, entryBusy, decimalMode, irqServiced;
  csf_entry_t entryOut;
  int n_mismatch = 0;
  int check_count = 0;
  csf_row_t rows[23] = '{
    '{OP_CLEAR_DEC, 8'h00, 8'h00, 8'h04, 8'h00, 2'h0},
    '{OP_SEC, 8'h00, 8'h00, 8'h05, 8'h00, 2'h0},
    '{OP_ADD, 8'h50, 8'h50, 8'hC4, 8'hA1, 2'h1},
    '{OP_ADD, 8'hFF, 8'h01, 8'h07, 8'h00, 2'h1},
    '{OP_CLEAR_CARRY, 8'h00, 8'h00, 8'h06, 8'h00, 2'h0},
    '{OP_SUB, 8'h80, 8'h01, 8'h45, 8'h7E, 2'h1},
    '{OP_CLEAR_OVF, 8'h00, 8'h00, 8'h05, 8'h00, 2'h0},
    '{OP_CMP, 8'h10, 8'h20, 8'h84, 8'hF0, 2'h1},
    '{OP_SHL, 8'h81, 8'h00, 8'h05, 8'h02, 2'h1},
    '{OP_ROR, 8'h01, 8'h00, 8'h85, 8'h80, 2'h1},
    '{OP_SHR, 8'h01, 8'h00, 8'h07, 8'h00, 2'h1},
    '{OP_ROL, 8'h80, 8'h00, 8'h05, 8'h01, 2'h1},
    '{OP_RESULT, 8'h00, 8'h00, 8'h07, 8'h00, 2'h1},
    '{OP_BIT, 8'h0F, 8'hC0, 8'hC7, 8'h00, 2'h0},
    '{OP_PULL, 8'hFF, 8'h00, 8'hCF, 8'h00, 2'h0},
    '{OP_ADD, 8'h09, 8'h01, 8'h0C, 8'h11, 2'h1},
    '{OP_CLEAR_DEC, 8'h00, 8'h00, 8'h04, 8'h00, 2'h0},
    '{OP_SET_DEC, 8'h00, 8'h00, 8'h0C, 8'h00, 2'h0},
    '{OP_CLEAR_MASK, 8'h00, 8'h00, 8'h08, 8'h00, 2'h0},
    '{OP_SET_MASK, 8'h00, 8'h00, 8'h0C, 8'h00, 2'h0},
    '{OP_RETURN_INT, 8'hDB, 8'h00, 8'hCB, 8'h00, 2'h0},
    '{OP_CLEAR_DEC, 8'h00, 8'h00, 8'hC3, 8'h00, 2'h0},
    '{OP_RETURN_INT, 8'h30, 8'h00, 8'h00, 8'h00, 2'h0}
  };

  // power-up decimal forced to one so the reset check can see it kept
  csf_status_flags #(.DEC_POWERUP(1'h1)) i_csf_status_flags (
    .clk_sys(clk_sys), .rst(rst), .opIn(opIn), .intrIn(intrIn),
    .statusOut(statusOut), .aluOut(aluOut), .aluValid(aluValid),
    .entryOut(entryOut), .entryBusy(entryBusy),
    .decimalMode(decimalMode), .irqServiced(irqServiced));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(logic got, logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask

  task automatic setOp(csf_opkind_t k);
    opIn = '{1'b1, k, 8'h00, 8'h00, 8'h00, 8'h00};
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (1000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end

  initial begin
    rst = 1'h1;
    opIn = '0;
    intrIn = '0;
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'h0;
    chk(statusOut, 8'h0C);
    $display("test reset done");
    // rows run back to back, one op per cycle
    foreach (rows[i]) begin
      opIn = '{1'b1, rows[i].k, rows[i].a, rows[i].b, rows[i].a, rows[i].a};
      tick();
      chk(statusOut, rows[i].st);
      chk1(decimalMode, rows[i].st[POS_DECIMAL]);
      if (rows[i].al != 2'h2) chk1(aluValid, rows[i].al[0]);
      if (rows[i].al == 2'h1) chk(aluOut, rows[i].alu);
    end
    opIn.opValid = 1'h0;
    $display("test table done");
    intrIn.irqReq = 1'h1;
    tick();
    chk1(irqServiced, 1'h1);
    chk1(entryBusy, 1'h1);
    intrIn.irqReq = 1'h0;
    setOp(OP_SEC);
    tick();
    chk({6'h00, entryOut.pushValid, entryOut.breakCause}, 8'h02);
    chk(entryOut.pushedStatus, 8'h00);
    tick();
    opIn.opValid = 1'h0;
    chk(statusOut, 8'h04);
    chk1(entryBusy, 1'h0);
    $display("test request entry done");
    // level request must wait for the mask, not be lost
    intrIn.irqReq = 1'h1;
    repeat (3) begin
      tick();
      chk1(irqServiced, 1'h0);
    end
    setOp(OP_CLEAR_MASK);
    tick();
    opIn.opValid = 1'h0;
    chk(statusOut, 8'h00);
    tick();
    intrIn.irqReq = 1'h0;
    chk1(irqServiced, 1'h1);
    tick();
    tick();
    chk(statusOut, 8'h04);
    $display("test masking done");
    setOp(OP_SW_BREAK);
    tick();
    opIn.opValid = 1'h0;
    chk1(entryBusy, 1'h1);
    chk1(irqServiced, 1'h0);
    tick();
    chk({6'h00, entryOut.pushValid, entryOut.breakCause}, 8'h03);
    chk(entryOut.pushedStatus, 8'h14);
    tick();
    chk(statusOut, 8'h14);
    $display("test break done");
    intrIn.nmiReq = 1'h1;
    tick();
    intrIn.nmiReq = 1'h0;
    chk1(entryBusy, 1'h1);
    tick();
    tick();
    chk(statusOut, 8'h04);
    $display("test nmi done");
    setOp(OP_SEC);
    tick();
    // decimal clear before reset must stay clear, unlike power-up value
    setOp(OP_CLEAR_DEC);
    tick();
    opIn.opValid = 1'h0;
    chk(statusOut, 8'h05);
    rst = 1'h1;
    tick();
    rst = 1'h0;
    chk(statusOut, 8'h04);
    chk1(decimalMode, 1'h0);
    $display("test second reset done");
    close_out();
  end
endmodule
`default_nettype wire
